// ### octal_dac_update_clear_control.sv
`timescale 1ns/1ps
module octal_dac_update_clear_control #(
  parameter int CHANNELS = dac_ctrl_pkg::CHANNELS,
  parameter int CODE_W   = dac_ctrl_pkg::CODE_W
) (
  input  wire logic                           clock_i,
  input  wire logic                           reset_n_i,
  input  wire logic                           scl_i,
  input  wire logic                           sda_i,
  input  wire logic                           addr_lsb_pin,
  input  wire logic                           load_outputs_n,
  input  wire logic                           clear_outputs_n,
  output logic                                sda_o,
  output logic                                sda_oe_o,
  output logic                                ref_drive_en_o,
  output logic [CHANNELS-1:0][CODE_W-1:0]     channel_code_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_SKIP = 4'h8
  } state_t;

  logic                             rst_s1;
  logic                             rst_n;
  logic                             clr_s1;
  logic                             clr_s2;
  logic                             clr_prev;
  logic                             ld_s1;
  logic                             ld_s2;
  logic                             scl_rise;
  logic                             scl_fall;
  logic                             start_cond;
  logic                             stop_cond;
  logic                             sda_bit;
  logic                             addr_lsb;
  state_t                           state,      next_state;
  logic [dac_ctrl_pkg::BYTE_W-1:0]  shift,      next_shift;
  logic [3:0]                       bit_cnt,    next_bit_cnt;
  logic [1:0]                       byte_cnt,   next_byte_cnt;
  logic                             acking,     next_acking;
  logic [dac_ctrl_pkg::WORD_W-1:0]  word,       next_word;
  logic                             word_valid, next_word_valid;
  logic [CHANNELS-1:0][CODE_W-1:0]  in_reg,     next_in_reg;
  logic [CHANNELS-1:0][CODE_W-1:0]  out_reg,    next_out_reg;
  logic [CHANNELS-1:0]              pending,    next_pending;
  logic [1:0]                       clr_sel,    next_clr_sel;
  logic                             ref_on,     next_ref_on;
  logic                             clr_fall;
  logic                             load_active;
  logic [3:0]                       cmd;
  logic [3:0]                       ch_sel;
  logic [CODE_W-1:0]                data;

  function automatic logic [CODE_W-1:0] clear_value(input logic [1:0] sel);
    case (sel)
      dac_ctrl_pkg::CLR_MID:  clear_value = {1'b1, {(CODE_W-1){1'b0}}};
      dac_ctrl_pkg::CLR_FULL: clear_value = {CODE_W{1'b1}};
      default:                clear_value = '0;
    endcase
  endfunction

  function automatic logic channel_hit(input logic [3:0] sel, input int idx);
    channel_hit = (sel == dac_ctrl_pkg::CH_ALL) || (sel == 4'(idx));
  endfunction

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  serial_target u_serial (
    .clock_i      (clock_i),
    .rst_n        (rst_n),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .addr_lsb_pin (addr_lsb_pin),
    .scl_rise_o   (scl_rise),
    .scl_fall_o   (scl_fall),
    .start_o      (start_cond),
    .stop_o       (stop_cond),
    .sda_bit_o    (sda_bit),
    .addr_lsb_o   (addr_lsb)
  );

  // Address byte, then four acknowledged data bytes per word
  always_comb begin
    next_state      = state;
    next_shift      = shift;
    next_bit_cnt    = bit_cnt;
    next_byte_cnt   = byte_cnt;
    next_acking     = acking;
    next_word       = word;
    next_word_valid = 1'b0;
    if (start_cond) begin
      next_state    = ST_ADDR;
      next_bit_cnt  = '0;
      next_byte_cnt = '0;
      next_acking   = 1'b0;
    end else if (stop_cond) begin
      next_state  = ST_IDLE;
      next_acking = 1'b0;
    end else if (scl_rise && !acking && (state == ST_ADDR || state == ST_DATA)) begin
      next_shift   = {shift[dac_ctrl_pkg::BYTE_W-2:0], sda_bit};
      next_bit_cnt = bit_cnt + 4'h1;
    end else if (scl_fall) begin
      if (acking) begin
        next_acking  = 1'b0;
        next_bit_cnt = '0;
      end else if (bit_cnt == dac_ctrl_pkg::BITS_DONE) begin
        case (state)
          ST_ADDR: begin
            if (shift == {dac_ctrl_pkg::ADDR_UPPER, addr_lsb, 1'b0}) begin
              next_state  = ST_DATA;
              next_acking = 1'b1;
            end else begin
              next_state = ST_SKIP;
            end
          end
          ST_DATA: begin
            next_acking     = 1'b1;
            next_word       = {word[dac_ctrl_pkg::WORD_W-dac_ctrl_pkg::BYTE_W-1:0], shift};
            next_byte_cnt   = byte_cnt + 2'h1;
            next_word_valid = (byte_cnt == dac_ctrl_pkg::LAST_BYTE);
          end
          default: next_state = ST_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      shift      <= '0;
      bit_cnt    <= '0;
      byte_cnt   <= '0;
      acking     <= 1'b0;
      word       <= '0;
      word_valid <= 1'b0;
    end else begin
      state      <= next_state;
      shift      <= next_shift;
      bit_cnt    <= next_bit_cnt;
      byte_cnt   <= next_byte_cnt;
      acking     <= next_acking;
      word       <= next_word;
      word_valid <= next_word_valid;
    end
  end

  assign cmd    = word[dac_ctrl_pkg::CMD_HI:dac_ctrl_pkg::CMD_LO];
  assign ch_sel = word[dac_ctrl_pkg::CH_HI:dac_ctrl_pkg::CH_LO];
  assign data   = word[CODE_W-1:0];

  // Clear edge is seen without any serial clock activity
  assign clr_fall    = clr_prev & ~clr_s2;
  assign load_active = ~ld_s2 & clr_s2;

  always_comb begin
    next_in_reg  = in_reg;
    next_out_reg = out_reg;
    next_pending = pending;
    next_clr_sel = clr_sel;
    next_ref_on  = ref_on;
    if (word_valid && cmd == dac_ctrl_pkg::CMD_CLR_SEL) begin
      next_clr_sel = data[1:0];
    end
    if (word_valid && cmd == dac_ctrl_pkg::CMD_REF) begin
      next_ref_on = data[0];
    end
    for (int i = 0; i < CHANNELS; i++) begin
      // Level-sensitive load also covers a pin tied low
      if (load_active && pending[i]) begin
        next_out_reg[i] = in_reg[i];
        next_pending[i] = 1'b0;
      end
      if (word_valid && channel_hit(ch_sel, i)) begin
        if (cmd == dac_ctrl_pkg::CMD_WRITE) begin
          next_in_reg[i]  = data;
          next_pending[i] = 1'b1;
        end else if (cmd == dac_ctrl_pkg::CMD_WR_UPD) begin
          next_in_reg[i]  = data;
          next_out_reg[i] = data;
          next_pending[i] = 1'b0;
        end
      end
      if (clr_fall) begin
        next_in_reg[i]  = clear_value(clr_sel);
        next_out_reg[i] = clear_value(clr_sel);
        next_pending[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      clr_s1   <= 1'b1;
      clr_s2   <= 1'b1;
      clr_prev <= 1'b1;
      ld_s1    <= 1'b1;
      ld_s2    <= 1'b1;
      in_reg   <= '0;
      out_reg  <= '0;
      pending  <= '0;
      clr_sel  <= dac_ctrl_pkg::CLR_ZERO;
      ref_on   <= 1'b0;
    end else begin
      clr_s1   <= clear_outputs_n;
      clr_s2   <= clr_s1;
      clr_prev <= clr_s2;
      ld_s1    <= load_outputs_n;
      ld_s2    <= ld_s1;
      in_reg   <= next_in_reg;
      out_reg  <= next_out_reg;
      pending  <= next_pending;
      clr_sel  <= next_clr_sel;
      ref_on   <= next_ref_on;
    end
  end

  assign sda_o          = 1'b0;
  assign sda_oe_o       = acking;
  assign ref_drive_en_o = ref_on;
  assign channel_code_o = out_reg;
endmodule

// ### dac_ctrl_pkg.sv
// Function
// - Load pulse copies pending inputs to outputs together
// - Load tied low still updates outputs correctly
// - Address pin sets slave address low bit
// - Reference pin driven only with internal reference
// - Clear acts on falling edge, not serial clock
// - Clear held low blocks all load transfers
// - Clear loads input and output with clear code
// - Clear code resets to zero scale
// - Serial bus shifts 32-bit command word
// - Data line only pulled low or released
// - Eight channels, each input and output register
package dac_ctrl_pkg;
  localparam int          CHANNELS    = 8;
  localparam int          CODE_W      = 16;
  localparam int          WORD_W      = 32;
  localparam int          BYTE_W      = 8;
  localparam logic [5:0]  ADDR_UPPER  = 6'h2a;
  localparam logic [3:0]  BITS_DONE   = 4'h8;
  localparam logic [1:0]  LAST_BYTE   = 2'h3;
  localparam int          CMD_HI      = 23;
  localparam int          CMD_LO      = 20;
  localparam int          CH_HI       = 19;
  localparam int          CH_LO       = 16;
  localparam logic [3:0]  CH_ALL      = 4'hf;
  localparam logic [3:0]  CMD_WRITE   = 4'h0;
  localparam logic [3:0]  CMD_WR_UPD  = 4'h1;
  localparam logic [3:0]  CMD_CLR_SEL = 4'h2;
  localparam logic [3:0]  CMD_REF     = 4'h3;
  localparam logic [1:0]  CLR_ZERO    = 2'h0;
  localparam logic [1:0]  CLR_MID     = 2'h1;
  localparam logic [1:0]  CLR_FULL    = 2'h2;
endpackage

// ### serial_target.sv
`timescale 1ns/1ps
module serial_target (
  input  wire logic        clock_i,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        addr_lsb_pin,
  output logic             scl_rise_o,
  output logic             scl_fall_o,
  output logic             start_o,
  output logic             stop_o,
  output logic             sda_bit_o,
  output logic             addr_lsb_o
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic       lsb_s1;
  logic       lsb_s2;

  // Stage 1 feeds only stage 2; edges use stages 2 and 3
  assign scl_rise_o = scl_s[1] & ~scl_s[2];
  assign scl_fall_o = ~scl_s[1] & scl_s[2];
  assign start_o    = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_o     = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  assign sda_bit_o  = sda_s[2];
  assign addr_lsb_o = lsb_s2;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_s    <= 3'h7;
      sda_s    <= 3'h7;
      lsb_s1   <= 1'b0;
      lsb_s2   <= 1'b0;
    end else begin
      scl_s    <= {scl_s[1:0], scl_i};
      sda_s    <= {sda_s[1:0], sda_i};
      lsb_s1   <= addr_lsb_pin;
      lsb_s2   <= lsb_s1;
    end
  end
endmodule

// ### dac_ctrl_props.sv
`timescale 1ns/1ps
module dac_ctrl_props #(
  parameter int CHANNELS = 8,
  parameter int CODE_W   = 16
) (
  input wire logic                            clock_i,
  input wire logic                            reset_n_i,
  input wire logic                            scl_i,
  input wire logic                            load_outputs_n,
  input wire logic                            clear_outputs_n,
  input wire logic                            sda_o,
  input wire logic                            sda_oe_o,
  input wire logic                            ref_drive_en_o,
  input wire logic [CHANNELS-1:0][CODE_W-1:0] channel_code_o
);
  logic same;
  always_comb begin
    same = 1'b1;
    for (int i = 1; i < CHANNELS; i++) same &= channel_code_o[i] == channel_code_o[0];
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_od; sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_ack_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack moved, clock high");
  property p_ack_hold; scl_i && sda_oe_o |=> sda_oe_o; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_ack_end; $rose(sda_oe_o) |-> ##[1:1000] !sda_oe_o; endproperty
  a_ack_end: assert property (p_ack_end) else $error("line never released");
  property p_ref; $changed(ref_drive_en_o) |-> !scl_i; endproperty
  a_ref: assert property (p_ref) else $error("ref enable off word");
  property p_quiet; (load_outputs_n && clear_outputs_n) [*5] ##1 scl_i |-> $stable(channel_code_o); endproperty
  a_quiet: assert property (p_quiet) else $error("outputs moved unloaded");
  property p_clr_hold; !clear_outputs_n [*7] |=> $stable(channel_code_o); endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("load ran in clear");
  property p_clr_code;
    $fell(clear_outputs_n) |-> ##6 same && channel_code_o[0] inside {16'h0000, 16'h8000, 16'hffff};
  endproperty
  a_clr_code: assert property (p_clr_code) else $error("clear code wrong");
  c_clr: cover property ($fell(clear_outputs_n));
  c_ack: cover property ($rose(sda_oe_o));
  c_load: cover property ($fell(load_outputs_n) && clear_outputs_n);
endmodule
bind octal_dac_update_clear_control dac_ctrl_props #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) dac_ctrl_props_i (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .load_outputs_n(load_outputs_n),
  .clear_outputs_n(clear_outputs_n), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .ref_drive_en_o(ref_drive_en_o), .channel_code_o(channel_code_o));

// ### bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model #(
  parameter int HALF = 8
) (
  input  wire logic clock_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output wire logic sda_o
);
  logic low = 1'b0;
  initial scl_o = 1'b1;
  assign sda_o = !(low || sda_oe_i);
  task automatic half();
    repeat (HALF) @(posedge clock_i);
  endtask
  task automatic bit_io(input logic b, output logic seen);
    low <= !b;
    half();
    scl_o <= 1'b1;
    half();
    seen = sda_o;
    scl_o <= 1'b0;
    half();
  endtask
  task automatic send(input logic [39:0] s, output logic ok);
    logic seen;
    ok = 1'b1;
    low <= 1'b1;
    half();
    scl_o <= 1'b0;
    // Data may only move once the clock is already low
    half();
    for (int i = 39; i >= 0; i--) begin
      bit_io(s[i], seen);
      if (i % 8 == 0) begin
        bit_io(1'b1, seen);
        ok = ok && !seen;
      end
    end
    low <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    low <= 1'b0;
    half();
  endtask
endmodule

// ### octal_dac_update_clear_control_tb.sv
`timescale 1ns/1ps
module octal_dac_update_clear_control_tb;
  logic             clock_i   = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             pin       = 1'b0;
  logic             load_n    = 1'b1;
  logic             clr_n     = 1'b1;
  logic             scl, sda, oe, ref_en;
  logic [7:0][15:0] code;
  int               fail_count  = 0;
  int               comparisons = 0;
  int               cycles      = 0;
  always #2.5 clock_i = !clock_i;
  bus_master_model bus_master_model_i (.clock_i(clock_i), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda));
  octal_dac_update_clear_control octal_dac_update_clear_control_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda), .addr_lsb_pin(pin),
    .load_outputs_n(load_n), .clear_outputs_n(clr_n), .sda_o(), .sda_oe_o(oe),
    .ref_drive_en_o(ref_en), .channel_code_o(code));
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t bit %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_code(input int ch, input logic [15:0] exp);
    comparisons++;
    if (code[ch] !== exp) begin
      fail_count++;
      $display("[ERR] %0t channel %0d is %h, expected %h", $time, ch, code[ch], exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [3:0] c, input logic [3:0] ch, input logic [15:0] d, input logic bad);
    logic ok;
    bus_master_model_i.send({dac_ctrl_pkg::ADDR_UPPER, pin ^ bad, 1'b0, 8'h00, c, ch, d}, ok);
    chk_bit(ok, !bad);
    tick(4);
  endtask
  task automatic pulse();
    load_n <= 1'b0;
    tick(4);
    load_n <= 1'b1;
    tick(8);
  endtask
  task automatic t_reset();
    chk_bit(ref_en, 1'b0);
    for (int i = 0; i < 8; i++) chk_code(i, 16'h0000);
  endtask
  task automatic t_addr();
    for (int p = 0; p < 2; p++) begin
      pin <= p[0];
      tick(4);
      wr(dac_ctrl_pkg::CMD_WR_UPD, 4'h7, 16'h0bad, 1'b1);
      chk_code(7, p ? 16'h1000 : 16'h0000);
      wr(dac_ctrl_pkg::CMD_WR_UPD, 4'h7, 16'h1000, 1'b0);
      chk_code(7, 16'h1000);
    end
  endtask
  task automatic t_load();
    wr(dac_ctrl_pkg::CMD_WRITE, 4'h1, 16'h1234, 1'b0);
    wr(dac_ctrl_pkg::CMD_WRITE, 4'h2, 16'h5678, 1'b0);
    chk_code(1, 16'h0000);
    pulse();
    chk_code(1, 16'h1234);
    chk_code(2, 16'h5678);
    chk_code(7, 16'h1000);
    wr(dac_ctrl_pkg::CMD_WR_UPD, dac_ctrl_pkg::CH_ALL, 16'h5a5a, 1'b0);
    for (int i = 0; i < 8; i++) chk_code(i, 16'h5a5a);
  endtask
  task automatic t_tied();
    load_n <= 1'b0;
    tick(4);
    wr(dac_ctrl_pkg::CMD_WRITE, 4'h4, 16'h9abc, 1'b0);
    chk_code(4, 16'h9abc);
    load_n <= 1'b1;
    tick(4);
  endtask
  task automatic t_clear(input logic set, input logic [1:0] sel, input logic [15:0] exp);
    if (set) wr(dac_ctrl_pkg::CMD_CLR_SEL, 4'h0, {14'h0000, sel}, 1'b0);
    clr_n <= 1'b0;
    tick(10);
    for (int i = 0; i < 8; i++) chk_code(i, exp);
    wr(dac_ctrl_pkg::CMD_WRITE, 4'h6, 16'h4321, 1'b0);
    pulse();
    chk_code(6, exp);
    clr_n <= 1'b1;
    tick(4);
    pulse();
    chk_code(6, 16'h4321);
  endtask
  task automatic t_ref();
    wr(dac_ctrl_pkg::CMD_REF, 4'h0, 16'h0001, 1'b0);
    chk_bit(ref_en, 1'b1);
    wr(dac_ctrl_pkg::CMD_REF, 4'h0, 16'h0000, 1'b0);
    chk_bit(ref_en, 1'b0);
  endtask
  initial begin
    tick(8);
    reset_n_i <= 1'b1;
    tick(6);
    t_reset();
    t_addr();
    t_load();
    t_tied();
    t_clear(1'b0, dac_ctrl_pkg::CLR_ZERO, 16'h0000);
    t_clear(1'b1, dac_ctrl_pkg::CLR_MID, 16'h8000);
    t_clear(1'b1, dac_ctrl_pkg::CLR_FULL, 16'hffff);
    t_ref();
    print_verdict();
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
endmodule
